// file: verilog/pmlc_pkg.sv
// Constants, types and field layout shared by both ends of the configuration link.
package pmlc_pkg;
    // ****************************************
    // Command codes and block lengths
    // ****************************************
    localparam logic [7:0] CMD_COMP = 8'hb1;
    localparam logic [7:0] CMD_LDO = 8'hb5;
    localparam logic [7:0] CMD_STATUS_BYTE = 8'h78;
    localparam logic [7:0] CMD_STATUS_CML = 8'h7e;
    localparam logic [7:0] CMD_CLEAR = 8'h03;
    localparam logic [7:0] LEN_COMP = 8'h05;
    localparam logic [7:0] LEN_ONE = 8'h01;
    localparam logic [7:0] LEN_NONE = 8'h00;
    localparam int COMP_BYTES = 5;

    // ****************************************
    // Compensation field positions
    // ****************************************
    localparam int CI_HI_MSB = 25;
    localparam int CI_HI_LSB = 24;
    localparam int CI_LO_MSB = 39;
    localparam int CI_LO_LSB = 38;
    localparam int CF_MSB = 37;
    localparam int CF_LSB = 33;
    localparam int CI_MULT_BIT = 32;
    localparam int CR_MSB = 31;
    localparam int CR_LSB = 26;
    localparam int VI_LO_MSB = 23;
    localparam int VI_LO_LSB = 22;
    localparam int VF_MSB = 21;
    localparam int VF_LSB = 17;
    localparam int VR_MSB = 15;
    localparam int VR_LSB = 10;
    localparam int VI_HI_MSB = 9;
    localparam int VI_HI_LSB = 8;
    localparam int VG_MSB = 5;
    localparam int VG_LSB = 4;
    localparam int CG_MSB = 1;
    localparam int CG_LSB = 0;

    // ****************************************
    // Regulator field, status bits, reset values
    // ****************************************
    localparam int LDO_MSB = 7;
    localparam int LDO_LSB = 4;
    localparam logic [3:0] LDO_CODE_MIN = 4'h3;
    localparam logic [3:0] LDO_CODE_MAX = 4'ha;
    localparam logic [3:0] LDO_RSVD_VAL = 4'h0;
    localparam int CML_IVC_BIT = 7;
    localparam int CML_IVD_BIT = 6;
    localparam int SB_CML_BIT = 1;
    localparam logic [39:0] COMP_RST = 40'h0;
    localparam logic [7:0] LDO_RST = 8'h00;
    localparam logic [7:0] CML_RST = 8'h00;

    // ****************************************
    // Timing
    // ****************************************
    localparam int CLK_PERIOD_NS = 40;
    localparam int LDO_ACTION_MAX_NS = 1000000;
    localparam int LDO_ACTION_MAX_CYC = LDO_ACTION_MAX_NS / CLK_PERIOD_NS;

    typedef enum logic [4:0] {
        DS_IDLE = 5'b00001,
        DS_WCNT = 5'b00010,
        DS_WDATA = 5'b00100,
        DS_RSEND = 5'b01000,
        DS_FIN = 5'b10000
    } pmlc_dstate_t;

    typedef enum logic [3:0] {
        HS_IDLE = 4'b0001,
        HS_CNT = 4'b0010,
        HS_DATA = 4'b0100,
        HS_WAIT = 4'b1000
    } pmlc_hstate_t;
endpackage

// file: verilog/pmlc_link_if.sv
// Byte-level block transaction link between the host end and the device end.
`timescale 1ns/1ns
`default_nettype none
interface pmlc_link_if;
    logic start;
    logic wr;
    logic [7:0] cmd;
    logic hvalid;
    logic [7:0] hbyte;
    logic dvalid;
    logic [7:0] dbyte;
    logic done;
    logic nak;
    logic alert;
    modport dev (
        input start, wr, cmd, hvalid, hbyte,
        output dvalid, dbyte, done, nak, alert
    );
    modport host (
        output start, wr, cmd, hvalid, hbyte,
        input dvalid, dbyte, done, nak, alert
    );
endinterface
`default_nettype wire

// file: verilog/pmlc_dev.sv
// Device end: compensation and regulator configuration registers with status.
`timescale 1ns/1ns
`default_nettype none
module pmlc_dev
    import pmlc_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic arst_n,
    // Link to host
    pmlc_link_if.dev link,
    // Power stage pins and power-on sources
    input wire logic conv_en_pin,
    input wire logic restore_pin,
    input wire logic pin_detect_sel,
    input wire logic [39:0] nvm_comp,
    input wire logic [39:0] pin_comp,
    input wire logic [7:0] nvm_ldo,
    // Applied settings to the control loop and regulator, and the pending flag
    output logic [3:0] cur_integ_cap_sel,
    output logic [4:0] cur_filter_cap_sel,
    output logic cur_integ_cap_mult,
    output logic [5:0] cur_gain_res_sel,
    output logic [3:0] volt_integ_cap_sel,
    output logic [4:0] volt_filter_cap_sel,
    output logic [5:0] volt_gain_res_sel,
    output logic [1:0] volt_transcond_sel,
    output logic [1:0] cur_transcond_sel,
    output logic [3:0] ldo_voltage_sel,
    output logic comp_pending
);
    // ****************************************
    // Pin synchronisers
    // ****************************************
    logic [1:0] conv_sync;
    logic [1:0] rest_sync;
    logic rest_prev;

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            conv_sync <= 2'h0;
            rest_sync <= 2'h0;
            rest_prev <= 1'b0;
        end else begin
            conv_sync <= {conv_sync[0], conv_en_pin};
            rest_sync <= {rest_sync[0], restore_pin};
            rest_prev <= rest_sync[1];
        end
    end

    // ****************************************
    // Transaction engine and registers
    // ****************************************
    pmlc_dstate_t state, next_state;
    logic [7:0] cmd_q, next_cmd_q;
    logic wr_q, next_wr_q;
    logic [7:0] cnt, next_cnt;
    logic [7:0] idx, next_idx;
    logic [COMP_BYTES-1:0][7:0] buf_q, next_buf_q;
    logic [39:0] comp, next_comp;
    logic [39:0] shadow, next_shadow;
    logic [7:0] ldo, next_ldo;
    logic [7:0] cml, next_cml;
    logic loaded, next_loaded;
    logic pend, next_pend;
    logic dvalid, next_dvalid;
    logic [7:0] dbyte, next_dbyte;
    logic done, next_done;
    logic nak, next_nak;
    logic alert, next_alert;

    always_comb begin
        logic [7:0] set_m;
        logic [7:0] clr_m;
        logic [7:0] sbyte;
        set_m = 8'h00;
        clr_m = 8'h00;
        sbyte = 8'h00;
        sbyte[SB_CML_BIT] = |cml;
        next_state = state;
        next_cmd_q = cmd_q;
        next_wr_q = wr_q;
        next_cnt = cnt;
        next_idx = idx;
        next_buf_q = buf_q;
        next_comp = comp;
        next_shadow = shadow;
        next_ldo = ldo;
        next_loaded = loaded;
        next_dvalid = 1'b0;
        next_dbyte = 8'h00;
        next_done = 1'b0;
        next_nak = 1'b0;
        if (!loaded) begin
            // Power-on values are taken on the first edge after reset release.
            next_loaded = 1'b1;
            next_comp = pin_detect_sel ? pin_comp : nvm_comp;
            next_ldo = {nvm_ldo[LDO_MSB:LDO_LSB], LDO_RSVD_VAL};
        end
        // The loop copy follows storage only when idle or on a restore.
        if (loaded && (!conv_sync[1] || (rest_sync[1] && !rest_prev))) begin
            next_shadow = comp;
        end
        unique case (state)
            DS_IDLE: begin
                if (link.start) begin
                    next_cmd_q = link.cmd;
                    next_wr_q = link.wr;
                    next_idx = 8'h00;
                    next_buf_q = '0;
                    if (link.wr) begin
                        next_state = DS_WCNT;
                    end else begin
                        next_state = DS_RSEND;
                        unique case (link.cmd)
                            CMD_COMP: begin
                                next_cnt = LEN_COMP;
                                next_buf_q = comp;
                            end
                            CMD_LDO: begin
                                next_cnt = LEN_ONE;
                                next_buf_q[0] = ldo;
                            end
                            CMD_STATUS_BYTE: begin
                                next_cnt = LEN_ONE;
                                next_buf_q[0] = sbyte;
                            end
                            CMD_STATUS_CML: begin
                                next_cnt = LEN_ONE;
                                next_buf_q[0] = cml;
                            end
                            default: begin
                                next_state = DS_IDLE;
                                set_m[CML_IVC_BIT] = 1'b1;
                                next_done = 1'b1;
                                next_nak = 1'b1;
                            end
                        endcase
                    end
                end
            end
            DS_WCNT: begin
                if (link.hvalid) begin
                    next_cnt = link.hbyte;
                    next_state = (link.hbyte == LEN_NONE) ? DS_FIN : DS_WDATA;
                end
            end
            DS_WDATA: begin
                if (link.hvalid) begin
                    // Bytes beyond the longest register are counted but dropped.
                    if (idx < 8'(COMP_BYTES)) begin
                        next_buf_q[idx[2:0]] = link.hbyte;
                    end
                    next_idx = idx + 8'h01;
                    if (idx + 8'h01 == cnt) begin
                        next_state = DS_FIN;
                    end
                end
            end
            DS_RSEND: begin
                next_dvalid = 1'b1;
                next_dbyte = (idx == 8'h00) ? cnt : buf_q[3'(idx - 8'h01)];
                next_idx = idx + 8'h01;
                if (idx == cnt) begin
                    next_state = DS_FIN;
                end
            end
            DS_FIN: begin
                next_state = DS_IDLE;
                next_done = 1'b1;
                if (wr_q) begin
                    unique case (cmd_q)
                        CMD_COMP: begin
                            if (cnt == LEN_COMP) begin
                                next_comp = buf_q;
                            end else begin
                                set_m[CML_IVD_BIT] = 1'b1;
                            end
                        end
                        CMD_LDO: begin
                            if (cnt == LEN_ONE && buf_q[0][LDO_MSB:LDO_LSB] >= LDO_CODE_MIN
                                && buf_q[0][LDO_MSB:LDO_LSB] <= LDO_CODE_MAX) begin
                                next_ldo = {buf_q[0][LDO_MSB:LDO_LSB], LDO_RSVD_VAL};
                            end else begin
                                set_m[CML_IVD_BIT] = 1'b1;
                            end
                        end
                        CMD_CLEAR: begin
                            if (cnt == LEN_NONE) begin
                                clr_m = 8'hff;
                            end else begin
                                set_m[CML_IVD_BIT] = 1'b1;
                            end
                        end
                        default: begin
                            set_m[CML_IVC_BIT] = 1'b1;
                        end
                    endcase
                    next_nak = |set_m;
                end
            end
        endcase
        // A fault raised in the cycle of a clear survives it.
        next_cml = (cml & ~clr_m) | set_m;
        next_alert = |next_cml;
        next_pend = next_comp != next_shadow;
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            state <= DS_IDLE;
            cmd_q <= 8'h00;
            wr_q <= 1'b0;
            cnt <= 8'h00;
            idx <= 8'h00;
            buf_q <= '0;
            comp <= COMP_RST;
            shadow <= COMP_RST;
            ldo <= LDO_RST;
            cml <= CML_RST;
            loaded <= 1'b0;
            pend <= 1'b0;
            dvalid <= 1'b0;
            dbyte <= 8'h00;
            done <= 1'b0;
            nak <= 1'b0;
            alert <= 1'b0;
        end else begin
            state <= next_state;
            cmd_q <= next_cmd_q;
            wr_q <= next_wr_q;
            cnt <= next_cnt;
            idx <= next_idx;
            buf_q <= next_buf_q;
            comp <= next_comp;
            shadow <= next_shadow;
            ldo <= next_ldo;
            cml <= next_cml;
            loaded <= next_loaded;
            pend <= next_pend;
            dvalid <= next_dvalid;
            dbyte <= next_dbyte;
            done <= next_done;
            nak <= next_nak;
            alert <= next_alert;
        end
    end

    // ****************************************
    // Outputs, all taken from flops
    // ****************************************
    assign link.dvalid = dvalid;
    assign link.dbyte = dbyte;
    assign link.done = done;
    assign link.nak = nak;
    assign link.alert = alert;
    assign cur_integ_cap_sel = {shadow[CI_HI_MSB:CI_HI_LSB], shadow[CI_LO_MSB:CI_LO_LSB]};
    assign cur_integ_cap_mult = shadow[CI_MULT_BIT];
    assign cur_filter_cap_sel = shadow[CF_MSB:CF_LSB];
    assign cur_gain_res_sel = shadow[CR_MSB:CR_LSB];
    assign volt_integ_cap_sel = {shadow[VI_HI_MSB:VI_HI_LSB], shadow[VI_LO_MSB:VI_LO_LSB]};
    assign volt_filter_cap_sel = shadow[VF_MSB:VF_LSB];
    assign volt_gain_res_sel = shadow[VR_MSB:VR_LSB];
    assign volt_transcond_sel = shadow[VG_MSB:VG_LSB];
    assign cur_transcond_sel = shadow[CG_MSB:CG_LSB];
    assign ldo_voltage_sel = ldo[LDO_MSB:LDO_LSB];
    assign comp_pending = pend;
endmodule // pmlc_dev
`default_nettype wire

// file: verilog/pmlc_host.sv
// Host end: turns user block requests into byte transactions on the link.
`timescale 1ns/1ns
`default_nettype none
module pmlc_host
    import pmlc_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic arst_n,
    // Link to device
    pmlc_link_if.host link,
    // User request
    input wire logic req_valid,
    input wire logic req_write,
    input wire logic [7:0] req_cmd,
    input wire logic [7:0] req_len,
    input wire logic [39:0] req_data,
    output logic req_ready,
    // User response
    output logic rsp_valid,
    output logic rsp_nak,
    output logic [39:0] rsp_data,
    output logic alert_seen
);
    pmlc_hstate_t state, next_state;
    logic [7:0] len, next_len;
    logic [7:0] idx, next_idx;
    logic [COMP_BYTES-1:0][7:0] data, next_data;
    logic ready, next_ready;
    logic rvalid, next_rvalid;
    logic rnak, next_rnak;
    logic start, next_start;
    logic wr, next_wr;
    logic [7:0] cmd, next_cmd;
    logic hvalid, next_hvalid;
    logic [7:0] hbyte, next_hbyte;
    logic alrt, next_alrt;

    always_comb begin
        next_state = state;
        next_len = len;
        next_idx = idx;
        next_data = data;
        next_ready = ready;
        next_rvalid = 1'b0;
        next_rnak = rnak;
        next_start = 1'b0;
        next_wr = wr;
        next_cmd = cmd;
        next_hvalid = 1'b0;
        next_hbyte = 8'h00;
        next_alrt = link.alert;
        unique case (state)
            HS_IDLE: begin
                if (req_valid && ready) begin
                    // The caller keeps reserved bits zero; they are sent as given.
                    next_ready = 1'b0;
                    next_start = 1'b1;
                    next_wr = req_write;
                    next_cmd = req_cmd;
                    next_len = req_len;
                    next_idx = 8'h00;
                    next_data = req_write ? req_data : '0;
                    next_state = req_write ? HS_CNT : HS_WAIT;
                end
            end
            HS_CNT: begin
                next_hvalid = 1'b1;
                next_hbyte = len;
                next_state = (len == LEN_NONE) ? HS_WAIT : HS_DATA;
            end
            HS_DATA: begin
                next_hvalid = 1'b1;
                next_hbyte = (idx < 8'(COMP_BYTES)) ? data[idx[2:0]] : 8'h00;
                next_idx = idx + 8'h01;
                if (idx + 8'h01 == len) begin
                    next_state = HS_WAIT;
                    next_idx = 8'h00;
                end
            end
            HS_WAIT: begin
                if (link.dvalid) begin
                    if (idx != 8'h00 && idx <= 8'(COMP_BYTES)) begin
                        next_data[3'(idx - 8'h01)] = link.dbyte;
                    end
                    next_idx = idx + 8'h01;
                end
                if (link.done) begin
                    next_state = HS_IDLE;
                    next_ready = 1'b1;
                    next_rvalid = 1'b1;
                    next_rnak = link.nak;
                end
            end
        endcase
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            state <= HS_IDLE;
            len <= 8'h00;
            idx <= 8'h00;
            data <= '0;
            ready <= 1'b1;
            rvalid <= 1'b0;
            rnak <= 1'b0;
            start <= 1'b0;
            wr <= 1'b0;
            cmd <= 8'h00;
            hvalid <= 1'b0;
            hbyte <= 8'h00;
            alrt <= 1'b0;
        end else begin
            state <= next_state;
            len <= next_len;
            idx <= next_idx;
            data <= next_data;
            ready <= next_ready;
            rvalid <= next_rvalid;
            rnak <= next_rnak;
            start <= next_start;
            wr <= next_wr;
            cmd <= next_cmd;
            hvalid <= next_hvalid;
            hbyte <= next_hbyte;
            alrt <= next_alrt;
        end
    end

    assign link.start = start;
    assign link.wr = wr;
    assign link.cmd = cmd;
    assign link.hvalid = hvalid;
    assign link.hbyte = hbyte;
    assign req_ready = ready;
    assign rsp_valid = rvalid;
    assign rsp_nak = rnak;
    assign rsp_data = data;
    assign alert_seen = alrt;
endmodule // pmlc_host
`default_nettype wire

// file: test/pmlc_checker.sv
// Concurrent checks on the block transfer link between the two ends.
`timescale 1ns/1ns
`default_nettype none
module pmlc_checker
    import pmlc_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic arst_n,
    // Link signals
    input wire logic start,
    input wire logic wr,
    input wire logic [7:0] cmd,
    input wire logic hvalid,
    input wire logic [7:0] hbyte,
    input wire logic dvalid,
    input wire logic [7:0] dbyte,
    input wire logic done,
    input wire logic nak,
    input wire logic alert
);
    default clocking @(posedge clk_sys);
    endclocking
    default disable iff (!arst_n);

    // ****************************************
    // Transfer shape and refusals
    // ****************************************
    AST_COMP_READ: assert property (start && !wr && cmd == CMD_COMP |=>
        ##1 (dvalid && dbyte == LEN_COMP) ##1 dvalid [*5] ##1 (done && !nak))
        else $error("bad comp read");
    AST_COMP_WRITE: assert property (start && wr && cmd == CMD_COMP
        ##1 (hvalid && hbyte == LEN_COMP) ##1 hvalid [*5] |=> ##1 (done && !nak))
        else $error("comp write not accepted");
    AST_BAD_COUNT: assert property (start && wr && cmd == CMD_COMP
        ##1 (hvalid && hbyte != LEN_COMP) |-> ##[1:8] (done && nak))
        else $error("wrong count not refused");
    AST_LDO_COUNT: assert property (start && !wr && cmd == CMD_LDO |=>
        ##1 (dvalid && dbyte == LEN_ONE))
        else $error("bad ldo count");
    AST_LDO_RSVD: assert property (start && !wr && cmd == CMD_LDO |=> ##2
        (dvalid && dbyte[3:0] == LDO_RSVD_VAL))
        else $error("ldo low nibble not zero");
    AST_LDO_CODE: assert property (start && !wr && cmd == CMD_LDO |=> ##2
        (dvalid && dbyte[7:4] >= LDO_CODE_MIN && dbyte[7:4] <= LDO_CODE_MAX))
        else $error("ldo code out of range");
    AST_LDO_BAD: assert property (start && wr && cmd == CMD_LDO ##1 hvalid
        ##1 (hvalid && (hbyte[7:4] < LDO_CODE_MIN || hbyte[7:4] > LDO_CODE_MAX))
        |=> ##1 (done && nak))
        else $error("bad ldo code not refused");
    AST_RO_WRITE: assert property (start && wr && (cmd == CMD_STATUS_BYTE ||
        cmd == CMD_STATUS_CML) ##1 (hvalid && hbyte == LEN_ONE) |-> !done [*3] ##1 (done && nak))
        else $error("read-only write not refused");
    AST_ALERT: assert property (done && nak |-> ##[0:2] alert)
        else $error("no alert after refusal");
endmodule // pmlc_checker
`default_nettype wire

// file: test/loop_comp_and_ldo_config_regs_tb.sv
// Self-checking bench joining the host end and the device end.
`timescale 1ns/1ns
`default_nettype none
module loop_comp_and_ldo_config_regs_tb
    import pmlc_pkg::*;
;
    typedef struct packed {logic nak; logic [39:0] mask; logic [39:0] data;} pmlc_note_t;
    // Random settings keep the reserved bits at zero.
    localparam logic [39:0] RMASK = 40'hfffffeff33;
    logic clk_sys, arst_n, conv_en_pin, restore_pin, pin_detect_sel, cur_integ_cap_mult;
    logic [39:0] nvm_comp, pin_comp, req_data, rsp_data, s, t;
    logic [7:0] nvm_ldo, req_cmd, req_len;
    logic req_valid, req_write, req_ready, rsp_valid, rsp_nak, alert_seen, comp_pending;
    logic [3:0] cur_integ_cap_sel, volt_integ_cap_sel, ldo_voltage_sel, cur;
    logic [4:0] cur_filter_cap_sel, volt_filter_cap_sel;
    logic [5:0] cur_gain_res_sel, volt_gain_res_sel;
    logic [1:0] volt_transcond_sel, cur_transcond_sel;
    int errors, n_checks;
    pmlc_note_t note_q[$];
    pmlc_note_t nt;
    pmlc_link_if link();
    pmlc_dev pmlc_dev_i (.clk_sys, .arst_n, .link(link), .conv_en_pin, .restore_pin,
        .pin_detect_sel, .nvm_comp, .pin_comp, .nvm_ldo, .cur_integ_cap_sel,
        .cur_filter_cap_sel, .cur_integ_cap_mult, .cur_gain_res_sel, .volt_integ_cap_sel,
        .volt_filter_cap_sel, .volt_gain_res_sel, .volt_transcond_sel, .cur_transcond_sel,
        .ldo_voltage_sel, .comp_pending);
    pmlc_host pmlc_host_i (.clk_sys, .arst_n, .link(link), .req_valid, .req_write, .req_cmd,
        .req_len, .req_data, .req_ready, .rsp_valid, .rsp_nak, .rsp_data, .alert_seen);
    pmlc_checker pmlc_checker_i (.clk_sys, .arst_n, .start(link.start), .wr(link.wr),
        .cmd(link.cmd), .hvalid(link.hvalid), .hbyte(link.hbyte), .dvalid(link.dvalid),
        .dbyte(link.dbyte), .done(link.done), .nak(link.nak), .alert(link.alert));

    initial begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end

    // ****************************************
    // Shared tasks
    // ****************************************
    task automatic chk(input logic [39:0] got, input logic [39:0] exp, input string m);
        n_checks++;
        if (got !== exp) begin
            errors++;
            $display("ERROR %0t %s", $time, m);
        end
    endtask

    task automatic wrap_up();
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic fields(input logic [39:0] v);
        logic [34:0] g;
        logic [34:0] e;
        g = {cur_integ_cap_sel, cur_filter_cap_sel, cur_integ_cap_mult, cur_gain_res_sel,
            volt_integ_cap_sel, volt_filter_cap_sel, volt_gain_res_sel, volt_transcond_sel,
            cur_transcond_sel};
        e = {v[25:24], v[39:38], v[37:33], v[32], v[31:26], v[9:8], v[23:22], v[21:17],
            v[15:10], v[5:4], v[1:0]};
        chk({5'h0, g}, {5'h0, e}, "applied fields");
    endtask

    // The expected answer is noted before the request, so the monitor never waits on it.
    task automatic xfer(input logic w, input logic [7:0] c, input logic [7:0] l,
            input logic [39:0] d, input logic en, input logic [39:0] ed);
        int k;
        note_q.push_back(pmlc_note_t'{en, w ? 40'h0 : ~(40'hffffffffff << (8 * l)), ed});
        @(posedge clk_sys);
        req_valid <= 1'b1;
        req_write <= w;
        req_cmd <= c;
        req_len <= l;
        req_data <= d;
        // Ready is looked at in mid-cycle, where it has settled, so the request drops
        // only after the edge that really takes it.
        @(negedge clk_sys);
        while (req_ready !== 1'b1) @(negedge clk_sys);
        @(posedge clk_sys);
        req_valid <= 1'b0;
        for (k = 0; k < 60 && rsp_valid !== 1'b1; k++) @(negedge clk_sys);
        if (rsp_valid !== 1'b1) begin
            errors++;
            $display("ERROR %0t no response", $time);
        end
        @(posedge clk_sys);
    endtask

    task automatic rst(input logic pd);
        arst_n <= 1'b0;
        pin_detect_sel <= pd;
        repeat (4) @(posedge clk_sys);
        arst_n <= 1'b1;
        repeat (4) @(posedge clk_sys);
    endtask

    initial begin
        forever begin
            @(negedge clk_sys);
            if (rsp_valid === 1'b1) begin
                if (note_q.size() > 0) begin
                    nt = note_q.pop_front();
                end else begin
                    nt = pmlc_note_t'{1'bx, '1, '0};
                end
                chk({39'h0, rsp_nak}, {39'h0, nt.nak}, "response refusal");
                chk(rsp_data & nt.mask, nt.data & nt.mask, "response data");
            end
        end
    end

    initial begin
        repeat (20000) @(posedge clk_sys);
        errors++;
        wrap_up();
    end

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        void'($urandom(93));
        arst_n = 1'b0;
        conv_en_pin = 1'b0;
        restore_pin = 1'b0;
        pin_detect_sel = 1'b0;
        nvm_comp = 40'({$urandom, $urandom}) & RMASK;
        pin_comp = 40'({$urandom, $urandom}) & RMASK;
        nvm_ldo = 8'h70;
        req_valid = 1'b0;
        req_write = 1'b0;
        req_cmd = 8'h00;
        req_len = 8'h00;
        req_data = 40'h0;
        errors = 0;
        n_checks = 0;
        for (int i = 1; i >= 0; i--) begin
            rst(i[0]);
            fields(i[0] ? pin_comp : nvm_comp);
            chk({36'h0, ldo_voltage_sel}, {36'h0, nvm_ldo[7:4]}, "regulator reset");
        end
        s = 40'({$urandom, $urandom}) & RMASK;
        xfer(1'b1, CMD_COMP, LEN_COMP, s, 1'b0, 40'h0);
        repeat (3) @(posedge clk_sys);
        fields(s);
        xfer(1'b0, CMD_COMP, LEN_COMP, 40'h0, 1'b0, s);
        conv_en_pin <= 1'b1;
        repeat (4) @(posedge clk_sys);
        t = ~s & RMASK;
        xfer(1'b1, CMD_COMP, LEN_COMP, t, 1'b0, 40'h0);
        repeat (4) @(posedge clk_sys);
        fields(s);
        chk({39'h0, comp_pending}, 40'h1, "pending set");
        xfer(1'b0, CMD_COMP, LEN_COMP, 40'h0, 1'b0, t);
        xfer(1'b1, CMD_COMP, 8'h04, s, 1'b1, 40'h0);
        xfer(1'b0, CMD_COMP, LEN_COMP, 40'h0, 1'b0, t);
        restore_pin <= 1'b1;
        repeat (6) @(posedge clk_sys);
        restore_pin <= 1'b0;
        repeat (2) @(posedge clk_sys);
        fields(t);
        chk({39'h0, comp_pending}, 40'h0, "pending clear");
        cur = nvm_ldo[7:4];
        for (int c = 0; c < 16; c++) begin
            xfer(1'b1, CMD_LDO, LEN_ONE, {32'h0, c[3:0], 4'h9}, c < 3 || c > 10, 40'h0);
            if (c >= 3 && c <= 10) cur = c[3:0];
            @(posedge clk_sys);
            chk({36'h0, ldo_voltage_sel}, {36'h0, cur}, "regulator select");
            xfer(1'b0, CMD_LDO, LEN_ONE, 40'h0, 1'b0, {32'h0, cur, 4'h0});
        end
        // The last valid code in the loop is the highest, and codes 11 to 15 are refused, so the lowest setting is never left selected.
        chk({36'h0, ldo_voltage_sel}, {36'h0, LDO_CODE_MAX}, "regulator left high");
        xfer(1'b0, CMD_CLEAR, LEN_ONE, 40'h0, 1'b1, 40'h0);
        xfer(1'b1, CMD_CLEAR, LEN_NONE, 40'h0, 1'b0, 40'h0);
        repeat (2) @(posedge clk_sys);
        chk({39'h0, alert_seen}, 40'h0, "alert after clear");
        xfer(1'b1, CMD_STATUS_CML, LEN_ONE, 40'h0, 1'b1, 40'h0);
        repeat (2) @(posedge clk_sys);
        chk({39'h0, alert_seen}, 40'h1, "alert raised");
        xfer(1'b0, CMD_STATUS_CML, LEN_ONE, 40'h0, 1'b0, 40'h80);
        xfer(1'b0, CMD_STATUS_BYTE, LEN_ONE, 40'h0, 1'b0, 40'h02);
        wrap_up();
    end
endmodule // loop_comp_and_ldo_config_regs_tb
`default_nettype wire
